// [verilog/spm_sched_map.svh]
// register offsets, field layout, reset values and timing counts of the scheduler
`ifndef SPM_SCHED_MAP_SVH
`define SPM_SCHED_MAP_SVH
`define SPM_OFF_CTRL 8'h00
`define SPM_OFF_REF 8'h04
`define SPM_OFF_SLEEP 8'h08
`define SPM_OFF_A_ON 8'h0c
`define SPM_OFF_B_ON 8'h10
`define SPM_OFF_CHAN 8'h14
`define SPM_OFF_STAT 8'h18
`define SPM_CTRL_EN_BIT 2
`define SPM_CHAN_B_LSB 2
`define SPM_CHAN_DUAL_BIT 4
`define SPM_RST_MODE 2'h0
`define SPM_RST_REF 8'h01
`define SPM_RST_SLEEP 14'h0001
`define SPM_RST_A_ON 16'h0001
`define SPM_RST_B_ON 16'h0001
`define SPM_RST_CHAN 5'h05
`define SPM_MODE_CONST 2'h0
`define SPM_MODE_FFB 2'h1
`define SPM_MODE_MIX 2'h2
`define SPM_SM_DIV 64
`define SPM_PRE_LAST 6'h3f
`define SPM_REF_ZERO_LEN 9'h100
`define SPM_SLEEP_ZERO_LEN 15'h4000
`endif

// [verilog/spm_sched_pkg.sv]
// types shared by the self polling scheduler and its bench
package spm_sched_pkg;
  typedef enum logic [5:0] {
    S_IDLE  = 6'h01,
    S_CONST = 6'h02,
    S_SRCH  = 6'h04,
    S_HOLD  = 6'h08,
    S_OFF   = 6'h10,
    S_RUN   = 6'h20
  } spm_state_e;

  // events from the synchronization and wake up detection logic
  typedef struct packed {
    logic sync_found;
    logic sync_timeout;
    logic wake_fail;
    logic wake_detect;
  } link_in_s;

  // receiver steering towards the same logic
  typedef struct packed {
    logic rx_on;
    logic cfg_b;
    logic [1:0] chan;
    logic chan_start;
    logic run_mode;
  } rx_ctl_s;
endpackage

// [verilog/spm_sched.sv]
// self polling on/off scheduler with apb register file
`include "spm_sched_map.svh"
module spm_sched
  import spm_sched_pkg::*;
(
  input wire logic pclk, // 100 mhz bus clock
  input wire logic presetn, // async reset, active low
  input wire logic ce, // clock enable, freezes all state when low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  input wire link_in_s link, // events from sync and wake up logic
  output rx_ctl_s ctl // receiver steering
);

  // whole block state in one struct: sequencer, timers, registers, bus answer
  // pre and ref_cnt form the timing base, on_cnt and off_cnt the phase timers
  // config fields keep their reset values until software writes them
  typedef struct packed {
    spm_state_e fsm;
    logic [5:0] pre;
    logic [7:0] ref_cnt;
    logic tick;
    logic [15:0] on_cnt;
    logic [14:0] off_cnt;
    logic [1:0] mode;
    logic en;
    logic [7:0] ref_val;
    logic [13:0] sleep;
    logic [15:0] a_on;
    logic [15:0] b_on;
    logic [4:0] chan_cfg;
    rx_ctl_s ctl;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } st_s;

  // reset image: scheduler parked in idle with the receiver off
  // config registers wake up with small legal counts, so a bare enable runs
  // the bus answer fields start low so no stray ready follows reset
  localparam st_s ST_RESET = '{
    fsm: S_IDLE,
    pre: 6'h00,
    ref_cnt: 8'h00,
    tick: 1'b0,
    on_cnt: 16'h0000,
    off_cnt: 15'h0000,
    mode: `SPM_RST_MODE,
    en: 1'b0,
    ref_val: `SPM_RST_REF,
    sleep: `SPM_RST_SLEEP,
    a_on: `SPM_RST_A_ON,
    b_on: `SPM_RST_B_ON,
    chan_cfg: `SPM_RST_CHAN,
    ctl: '0,
    prdata: 32'h00000000,
    pready: 1'b0,
    pslverr: 1'b0
  };

  st_s st_r;
  st_s st_nxt;

  // decoded configuration
  logic [8:0] ref_len;
  logic [1:0] a_last;
  logic [1:0] b_last;
  logic dual;
  logic mode_ffb;
  logic mode_mix;
  logic ffb_chan;
  logic expired;
  // step requests raised by the sequencer, acted on further down
  logic adv;
  logic finish;
  logic begin_p;
  // read data and address hit from the decode
  logic hit;
  logic [31:0] rdata;

  // decoded configuration; a zero channel count is taken as one channel
  // pure combinational helpers; nothing here holds state
  always_comb begin
    ref_len = (st_r.ref_val == 8'h00) ? `SPM_REF_ZERO_LEN : {1'b0, st_r.ref_val};
    // counts are channel totals; the walk compares against the last index
    a_last = (st_r.chan_cfg[1:0] == 2'h0) ? 2'h0 : st_r.chan_cfg[1:0] - 2'h1;
    b_last = (st_r.chan_cfg[3:2] == 2'h0) ? 2'h0 : st_r.chan_cfg[3:2] - 2'h1;
    dual = st_r.chan_cfg[`SPM_CHAN_DUAL_BIT];
    // code 11 is reserved and falls through to constant on/off
    mode_ffb = (st_r.mode == `SPM_MODE_FFB);
    mode_mix = (st_r.mode == `SPM_MODE_MIX);
    // in mixed mode only the b channels run the fast fall back way
    ffb_chan = mode_ffb || (mode_mix && st_r.ctl.cfg_b);
    // an on count of zero or one ends at the next tick, so zero acts as one
    expired = st_r.tick && (st_r.on_cnt <= 16'h0001);
  end

  // register read mux and address decode
  always_comb begin
    hit = 1'b1;
    rdata = 32'h00000000;
    // unmapped addresses answer with an error and zero data
    unique case (paddr)
      `SPM_OFF_CTRL: rdata = {29'h0, st_r.en, st_r.mode};
      `SPM_OFF_REF: rdata = {24'h0, st_r.ref_val};
      `SPM_OFF_SLEEP: rdata = {18'h0, st_r.sleep};
      `SPM_OFF_A_ON: rdata = {16'h0, st_r.a_on};
      `SPM_OFF_B_ON: rdata = {16'h0, st_r.b_on};
      `SPM_OFF_CHAN: rdata = {27'h0, st_r.chan_cfg};
      // state above the steering bits, bit 0 reads as zero
      `SPM_OFF_STAT: rdata = {19'h0, st_r.fsm, st_r.ctl, 1'b0};
      default: hit = 1'b0;
    endcase
  end

  // next state of the whole block
  always_comb begin
    st_nxt = st_r;
    // one-cycle strobes default low; every other field holds
    st_nxt.tick = 1'b0;
    st_nxt.ctl.chan_start = 1'b0;
    st_nxt.pready = 1'b0;
    st_nxt.pslverr = 1'b0;

    // step requests, raised by the sequencer below
    adv = 1'b0;
    finish = 1'b0;
    begin_p = 1'b0;

    // state machine clock is pclk/64, then the reference timer divides it
    // tick is a one-cycle strobe, so each phase timer moves once per period
    // a reference value of zero divides by 256
    // the prescaler free-runs whatever the state, so the tick never drifts
    if (st_r.pre == `SPM_PRE_LAST) begin
      st_nxt.pre = 6'h00;
      if ({1'b0, st_r.ref_cnt} + 9'h001 == ref_len) begin
        st_nxt.ref_cnt = 8'h00;
        st_nxt.tick = 1'b1;
      end else begin
        st_nxt.ref_cnt = st_r.ref_cnt + 8'h01;
      end
    end else begin
      st_nxt.pre = st_r.pre + 6'h01;
    end

    // schedule sequencing
    unique case (st_r.fsm)
      S_IDLE: begin
        // the first period may run short by up to one tick
        begin_p = st_r.en;
      end
      S_CONST: begin
        // the channel keeps its whole on time; of the link verdicts only a wake up detect ends it
        if (expired) begin
          adv = 1'b1;
        end else if (st_r.tick) begin
          st_nxt.on_cnt = st_r.on_cnt - 16'h0001;
        end
      end
      S_SRCH: begin
        // one on timer shared by every channel; expiry ends the phase mid-channel
        if (expired) begin
          finish = 1'b1;
        end else begin
          if (st_r.tick) begin
            st_nxt.on_cnt = st_r.on_cnt - 16'h0001;
          end
          // a failed criterion, or no sync by the timeout, drops the channel
          if (link.wake_fail) begin
            adv = 1'b1;
          end else if (link.sync_timeout && !link.sync_found) begin
            adv = 1'b1;
          end
        end
      end
      S_HOLD: begin
        // receiver already off; timer keeps running so the period holds
        if (expired) begin
          finish = 1'b1;
        end else if (st_r.tick) begin
          st_nxt.on_cnt = st_r.on_cnt - 16'h0001;
        end
      end
      S_OFF: begin
        // the off timer was loaded right after a tick, so its length is exact
        if (st_r.tick) begin
          if (st_r.off_cnt <= 15'h0001) begin
            begin_p = 1'b1;
          end else begin
            st_nxt.off_cnt = st_r.off_cnt - 15'h0001;
          end
        end
      end
      S_RUN: begin
        // receiver stays on until software clears the enable
        st_nxt.ctl.rx_on = 1'b1;
      end
    endcase

    // step to the next channel, a channels first then b
    // a switch to b reloads the b time except in pure fast fall back
    if (adv) begin
      if (!st_r.ctl.cfg_b && st_r.ctl.chan != a_last) begin
        st_nxt.ctl.chan = st_r.ctl.chan + 2'h1;
        st_nxt.ctl.chan_start = 1'b1;
        // fast fall back channels are not reloaded: the rest of the on time
        // carries over to the next channel
        if (!ffb_chan) begin
          st_nxt.on_cnt = st_r.a_on;
        end
      end else if (!st_r.ctl.cfg_b && dual) begin
        st_nxt.ctl.cfg_b = 1'b1;
        st_nxt.ctl.chan = 2'h0;
        st_nxt.ctl.chan_start = 1'b1;
        // pure fast fall back keeps the a timer; b on time unused there
        if (!mode_ffb) begin
          st_nxt.on_cnt = st_r.b_on;
        end
        st_nxt.fsm = (mode_ffb || mode_mix) ? S_SRCH : S_CONST;
      end else if (st_r.ctl.cfg_b && st_r.ctl.chan != b_last) begin
        st_nxt.ctl.chan = st_r.ctl.chan + 2'h1;
        st_nxt.ctl.chan_start = 1'b1;
        if (!ffb_chan) begin
          st_nxt.on_cnt = st_r.b_on;
        end
      end else if (st_r.fsm == S_CONST) begin
        finish = 1'b1;
      end else begin
        // last searched channel: receiver off, timer keeps the period
        st_nxt.fsm = S_HOLD;
        st_nxt.ctl.rx_on = 1'b0;
      end
    end

    // on phase over: sleep for the programmed count
    // a count of zero stands for the longest sleep
    if (finish) begin
      st_nxt.fsm = S_OFF;
      st_nxt.ctl.rx_on = 1'b0;
      st_nxt.off_cnt = (st_r.sleep == 14'h0000) ?
                       `SPM_SLEEP_ZERO_LEN : {1'b0, st_r.sleep};
    end

    // new master period, first a channel
    // pure fast fall back searches from the start; other modes time each a channel
    if (begin_p) begin
      st_nxt.fsm = mode_ffb ? S_SRCH : S_CONST;
      st_nxt.ctl.cfg_b = 1'b0;
      st_nxt.ctl.chan = 2'h0;
      st_nxt.ctl.chan_start = 1'b1;
      st_nxt.ctl.rx_on = 1'b1;
      st_nxt.on_cnt = st_r.a_on;
    end

    // wake up wins over any schedule step
    // channel and configuration stay frozen so software sees where it woke
    // hold and off ignore wake events, the receiver is off there
    if ((st_r.fsm == S_CONST || st_r.fsm == S_SRCH) && link.wake_detect) begin
      st_nxt.fsm = S_RUN;
      st_nxt.ctl.run_mode = 1'b1;
      st_nxt.ctl.rx_on = 1'b1;
      st_nxt.ctl.chan_start = 1'b0;
      st_nxt.ctl.chan = st_r.ctl.chan;
      st_nxt.ctl.cfg_b = st_r.ctl.cfg_b;
    end

    // disabling parks the scheduler with the receiver off
    // a later enable starts afresh from the first a channel
    if (!st_r.en) begin
      st_nxt.fsm = S_IDLE;
      st_nxt.ctl = '0;
    end

    // apb: data latched in setup, zero wait access
    // the answer is registered, so pready stands in the first access cycle
    if (psel && !penable) begin
      st_nxt.pready = 1'b1;
      st_nxt.pslverr = !hit;
      st_nxt.prdata = (pwrite || !hit) ? 32'h00000000 : rdata;
    end

    // writes land at the edge that sees pready high; high bits are dropped
    if (psel && penable && st_r.pready && pwrite && hit) begin
      unique case (paddr)
        `SPM_OFF_CTRL: begin
          st_nxt.mode = pwdata[1:0];
          st_nxt.en = pwdata[`SPM_CTRL_EN_BIT];
        end
        `SPM_OFF_REF: st_nxt.ref_val = pwdata[7:0];
        `SPM_OFF_SLEEP: st_nxt.sleep = pwdata[13:0];
        `SPM_OFF_A_ON: st_nxt.a_on = pwdata[15:0];
        `SPM_OFF_B_ON: st_nxt.b_on = pwdata[15:0];
        `SPM_OFF_CHAN: st_nxt.chan_cfg = pwdata[4:0];
        default: st_nxt.en = st_r.en; // status is read only
      endcase
    end
  end

  // single state register, frozen while ce is low
  // ce low stalls the bus answer too; a setup edge lost to ce low never gets pready, so the master hangs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= ST_RESET;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  // every output comes straight from the state register
  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign ctl = st_r.ctl;

endmodule // spm_sched

// [bench/spm_sched_properties.sv]
// port level assertions of the self polling scheduler
module spm_sched_properties
  import spm_sched_pkg::*;
(
  input wire logic pclk, // clock
  input wire logic presetn, // reset, low
  input wire logic ce, // clock enable
  input wire logic psel, // apb select
  input wire logic penable, // apb access
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire link_in_s link, // link events
  input wire rx_ctl_s ctl // steering
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // apb answer: zero wait states, one cycle wide
  a_ready_zero_wait: assert property (psel && !penable && ce |=> pready)
    else $error("no ready after setup");
  a_ready_cause: assert property (pready |-> $past(psel) && !$past(penable) ##1 !pready)
    else $error("stray or long ready");
  a_err_zero_data: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error without ready or with data");
  a_run_cause: assert property ($rose(ctl.run_mode) |-> $past(link.wake_detect))
    else $error("run mode without wake up");
  a_run_rx_on: assert property (ctl.run_mode |-> ctl.rx_on)
    else $error("receiver off in run mode");
  // each on phase opens on the first config a channel
  a_first_chan_a: assert property ($rose(ctl.rx_on) && !ctl.run_mode |->
    ctl.chan_start && !ctl.cfg_b && ctl.chan == 2'h0)
    else $error("on phase not opened on a0");
  a_b_starts_fresh: assert property ($rose(ctl.cfg_b) |-> ctl.chan_start && ctl.chan == 2'h0)
    else $error("config b not entered at b0");
  a_start_pulse: assert property (ctl.chan_start |-> ctl.rx_on ##1 !ctl.chan_start)
    else $error("channel start bad");
  c_run: cover property ($rose(ctl.run_mode));
  c_err: cover property (pslverr);
  c_cfg_b: cover property ($rose(ctl.cfg_b));
endmodule // spm_sched_properties

bind spm_sched spm_sched_properties chk (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
  .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link), .ctl(ctl));

// [bench/spm_link_model.sv]
// partner model of the sync and wake up detection logic
module spm_link_model
  import spm_sched_pkg::*;
(
  input wire logic pclk, // clock
  input wire logic presetn, // reset, low
  input wire rx_ctl_s ctl, // steering in
  input wire logic [3:0] dly, // cycles to a verdict
  input wire logic sync_ok, // stream present
  input wire logic wake_go, // criterion met
  output link_in_s link // events out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_r;
  // one verdict per channel, quiet until the next start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link <= '0;
      cnt_r <= '0;
    end else begin
      link.sync_timeout <= 1'b0;
      link.wake_fail <= 1'b0;
      link.wake_detect <= 1'b0;
      if (ctl.chan_start) begin
        cnt_r <= dly;
        link.sync_found <= sync_ok; // lock held only on a live stream
      end else if (!ctl.rx_on) begin
        link.sync_found <= 1'b0; // lock lost when receiver off
        cnt_r <= '0;
      end else if (cnt_r != 4'h0) begin
        cnt_r <= cnt_r - 4'h1;
        if (cnt_r == 4'h1) begin
          link.wake_detect <= wake_go && sync_ok;
          link.wake_fail <= !wake_go && sync_ok;
          link.sync_timeout <= !sync_ok; // no lock, search times out
        end
      end
    end
  end
endmodule // spm_link_model

// [bench/spm_sched_tb.sv]
// self checking bench for the self polling scheduler
`include "spm_sched_map.svh"
module spm_sched_tb
  import spm_sched_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, rnd;
  logic [3:0] dly = 4'h2;
  logic sync_ok = 0, wake_go = 0;
  link_in_s link;
  rx_ctl_s ctl;
  int seed = 19, miscompares = 0, compares = 0, cyc = 0;
  int q_t[$], q_c[$], q0[$], exp_q[$], got_q[$];

  spm_sched dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link), .ctl(ctl));
  spm_link_model far (.pclk(pclk), .presetn(presetn), .ctl(ctl), .dly(dly), .sync_ok(sync_ok),
    .wake_go(wake_go), .link(link));

  initial forever #5 pclk = ~pclk;
  // log every channel start with its cycle stamp
  always @(posedge pclk) begin
    cyc++;
    if (ctl.chan_start === 1'b1) begin
      q_t.push_back(cyc);
      q_c.push_back({ctl.cfg_b, ctl.chan});
      if ({ctl.cfg_b, ctl.chan} === 3'h0) q0.push_back(cyc);
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask

  task test_done;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // one apb transfer, idle edge first so no signal is driven twice per step
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin chk(0, 1, "apb hang"); test_done(); end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  // run one mode, measure a full master period and its channel order
  task poll(input logic [1:0] mode, input int ticks);
    int n;
    q_t.delete(); q_c.delete(); q0.delete(); got_q.delete();
    dly <= 4'(2 + {$random(seed)} % 8);
    apb(1, `SPM_OFF_CTRL, 32'h4 | mode);
    n = 0;
    while (q0.size() < 3 && n < 5000) begin @(posedge pclk); n++; end
    if (n >= 5000) begin chk(0, 1, "no period"); test_done(); end
    chk(q0[2] - q0[1], ticks * 64, "master period");
    foreach (q_t[j]) if (q_t[j] >= q0[1] && q_t[j] < q0[2]) got_q.push_back(q_c[j]);
    chk(got_q.size(), exp_q.size(), "channel count");
    foreach (exp_q[j]) chk(got_q[j], exp_q[j], "channel order");
    apb(1, `SPM_OFF_CTRL, 32'h0);
    $display("mode %0d done", mode);
  endtask

  initial begin
    logic [31:0] rst_v[6];
    rst_v = '{32'h0, 32'h1, 32'h1, 32'h1, 32'h1, 32'h5};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rst_v[i]) begin
      apb(0, 8'(4 * i), 32'h0);
      chk(rd, rst_v[i], "reset value");
    end
    apb(0, 8'h1c, 32'h0);
    chk(32'(er), 32'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    apb(1, `SPM_OFF_STAT, 32'hffff);
    chk(32'(er), 32'h0, "status write");
    rnd = 32'({$random(seed)});
    apb(1, `SPM_OFF_SLEEP, rnd);
    apb(0, `SPM_OFF_SLEEP, 32'h0);
    chk(rd, rnd & 32'h3fff, "sleep readback");
    $display("register test done");
    // two a and two b channels, on times above the partner's verdict delay
    apb(1, `SPM_OFF_CHAN, 32'h1a);
    apb(1, `SPM_OFF_A_ON, 32'h2);
    apb(1, `SPM_OFF_B_ON, 32'h3);
    apb(1, `SPM_OFF_SLEEP, 32'h4);
    exp_q = '{0, 1, 4, 5};
    sync_ok <= 1'b1;
    poll(`SPM_MODE_CONST, 2 * 2 + 2 * 3 + 4);
    sync_ok <= 1'b0;
    poll(`SPM_MODE_FFB, 2 + 4);
    sync_ok <= 1'b1;
    poll(`SPM_MODE_MIX, 2 * 2 + 3 + 4);
    // clock enable low must freeze the first a channel past its on time
    apb(1, `SPM_OFF_CTRL, 32'h4);
    repeat (2) @(posedge pclk);
    ce <= 1'b0;
    @(posedge pclk);
    rd = 32'(ctl);
    repeat (200) @(posedge pclk);
    chk(32'(ctl), rd, "frozen by ce");
    ce <= 1'b1;
    apb(1, `SPM_OFF_CTRL, 32'h0);
    $display("clock enable test done");
    wake_go <= 1'b1;
    apb(1, `SPM_OFF_CTRL, 32'h4);
    repeat (400) if (ctl.run_mode !== 1'b1) @(posedge pclk);
    chk({ctl.run_mode, ctl.rx_on}, 2'h3, "run mode");
    apb(1, `SPM_OFF_CTRL, 32'h0);
    repeat (8) if (ctl.rx_on !== 1'b0) @(posedge pclk);
    chk({ctl.run_mode, ctl.rx_on}, 2'h0, "run mode cleared");
    $display("wake test done");
    test_done();
  end
endmodule // spm_sched_tb
